// [logic/unb_ninth_bit_ctrl.sv]
// Ninth-bit mode control: register, receive filter and character framer
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ns
// Overview of operation
// RULE1: Filter mode 00 requests an interrupt for every received byte.
// RULE2: Filter mode 01 requests only for address bytes, never data bytes.
// RULE3: Mode 10 requests on matching address, then data until mismatch.
// RULE4: Mode 11 requests only for data after a matching address.
// RULE5: Enable bit switches ninth-bit operation on or off; reset off.
// RULE6: Enabled transmitter sends the stored ninth bit value per character.
// RULE7: Driver enable active high with polarity 0, low with 1.
// RULE8: Control register reachable only in bank 000; eight bits, reset zero.
// RULE9: Ninth bit goes after the eight data bits, before the stop bit.
// RULE10: Ninth bit 1 marks an address byte, 0 a data byte.
// RULE11: Address byte compared with stored byte; result held until next one.
module unb_ninth_bit_ctrl (
    input  wire logic            clk_i,        // System clock
    input  wire logic            rst_i,        // Async reset, high
    input  wire logic            ce_i,         // Clock enable
    input  wire logic [2:0]      bank_select_field_i, // Register bank
    input  wire unb_pkg::unb_req_t req_i,      // Register request
    output logic [7:0]           rd_data_o,    // Read data, next cycle
    output logic                 irq_o,        // Level interrupt
    input  wire logic            rx_valid_i,   // Character received
    input  wire unb_pkg::unb_rx_t rx_i,        // Received character
    output logic                 rx_irq_req_o, // Filtered receive request
    input  wire logic            baud_tick_i,  // One pulse per bit time
    input  wire logic            tx_start_i,   // Start a character
    input  wire logic [7:0]      tx_data_i,    // Character to send
    output logic                 tx_busy_o,    // Framer busy
    output logic                 txd_o,        // Serial data out
    output logic                 line_driver_enable_o // Driver enable pin
);

    unb_pkg::unb_state_t q;
    unb_pkg::unb_state_t d;

    // Filter mode sits in two split bits of the control byte
    function automatic logic [1:0] mode_of(input logic [7:0] c);
        mode_of = {c[unb_pkg::CTRL_MODE_HI], c[unb_pkg::CTRL_MODE_LO]};
    endfunction : mode_of

    logic       bank_ok;
    logic       is_addr;
    logic       hit;
    logic       rx_req;
    logic       tx_done;
    logic [2:0] st_clr;
    logic [2:0] st_set;

    // Next state of the whole block
    always_comb
    begin
        d       = q;
        bank_ok = (bank_select_field_i == unb_pkg::BANK_MP);
        is_addr = q.ctrl[unb_pkg::CTRL_EN] & rx_i.ninth; // RULE10
        hit     = (rx_i.data == q.acmp);                 // RULE11
        rx_req  = 1'b0;
        tx_done = 1'b0;
        st_clr  = unb_pkg::STAT_RST;

        // Receive filter; plain 8-bit operation passes every byte
        if (rx_valid_i)
        begin
            if (!q.ctrl[unb_pkg::CTRL_EN])
            begin
                rx_req = 1'b1;
            end
            else
            begin
                case (mode_of(q.ctrl))
                    unb_pkg::MODE_ALL:   rx_req = 1'b1;    // RULE1
                    unb_pkg::MODE_ADDR:  rx_req = is_addr; // RULE2
                    unb_pkg::MODE_MATCH:
                        rx_req = is_addr ? hit : q.match;  // RULE3
                    unb_pkg::MODE_DATA:
                        rx_req = !is_addr && q.match;      // RULE4
                    default: rx_req = 1'b0;
                endcase
            end
            // Match kept until the next address character
            if (is_addr)
            begin
                d.match = hit; // RULE11
            end
        end
        d.req = rx_req;

        // Register writes; control only through the right bank
        if (req_i.wr)
        begin
            case (req_i.addr)
                unb_pkg::CTRL_ADDR:
                    if (bank_ok)
                    begin
                        d.ctrl = req_i.wdata; // RULE8 RULE5
                    end
                unb_pkg::ACMP_ADDR: d.acmp = req_i.wdata;
                unb_pkg::MASK_ADDR:
                    d.mask = req_i.wdata[unb_pkg::ST_W-1:0];
                unb_pkg::STAT_ADDR:
                    st_clr = req_i.wdata[unb_pkg::ST_W-1:0];
                default: ;
            endcase
        end

        // Register reads answer the next cycle; unmapped reads give zero
        d.rdata = 8'h00;
        if (req_i.rd)
        begin
            case (req_i.addr)
                unb_pkg::CTRL_ADDR:
                    d.rdata = bank_ok ? q.ctrl : 8'h00; // RULE8
                unb_pkg::ACMP_ADDR: d.rdata = q.acmp;
                unb_pkg::STAT_ADDR:
                    d.rdata = {{(8-unb_pkg::ST_W){1'b0}}, q.stat};
                unb_pkg::MASK_ADDR:
                    d.rdata = {{(8-unb_pkg::ST_W){1'b0}}, q.mask};
                default: d.rdata = 8'h00;
            endcase
        end

        // Transmit framer: start, eight data bits, optional ninth, stop
        case (q.tx)
            unb_pkg::TX_IDLE:
                if (tx_start_i)
                begin
                    d.shift     = tx_data_i;
                    d.ninth_bit = q.ctrl[unb_pkg::CTRL_TXB]; // RULE6
                    d.ninth_en  = q.ctrl[unb_pkg::CTRL_EN];  // RULE5
                    d.tx        = unb_pkg::TX_START;
                end
            unb_pkg::TX_START:
                if (baud_tick_i)
                begin
                    d.tx  = unb_pkg::TX_DATA;
                    d.cnt = 3'h0;
                end
            unb_pkg::TX_DATA:
                if (baud_tick_i)
                begin
                    d.shift = {1'b0, q.shift[7:1]};
                    d.cnt   = q.cnt + 3'h1;
                    if (q.cnt == unb_pkg::BIT_LAST)
                    begin
                        d.tx = q.ninth_en ? unb_pkg::TX_NINTH
                                          : unb_pkg::TX_STOP; // RULE9
                    end
                end
            unb_pkg::TX_NINTH:
                if (baud_tick_i)
                begin
                    d.tx = unb_pkg::TX_STOP; // RULE9
                end
            unb_pkg::TX_STOP:
                if (baud_tick_i)
                begin
                    d.tx    = unb_pkg::TX_IDLE;
                    tx_done = 1'b1;
                end
            default: d.tx = unb_pkg::TX_IDLE;
        endcase

        // Line level follows the next framer state
        case (d.tx)
            unb_pkg::TX_START: d.txd = 1'b0;
            unb_pkg::TX_DATA:  d.txd = d.shift[0];
            unb_pkg::TX_NINTH: d.txd = d.ninth_bit; // RULE6
            default:           d.txd = 1'b1;
        endcase
        d.busy = (d.tx != unb_pkg::TX_IDLE);
        // Polarity applied live, so a change takes effect at once
        d.de = d.busy ^ d.ctrl[unb_pkg::CTRL_POL]; // RULE7

        // Sticky events; a new event beats a same-cycle clear
        st_set = '0;
        st_set[unb_pkg::ST_RXREQ]  = rx_req;
        st_set[unb_pkg::ST_ADDR]   = rx_valid_i & is_addr; // RULE10
        st_set[unb_pkg::ST_TXDONE] = tx_done;
        d.stat = (q.stat & ~st_clr) | st_set;
        d.irq  = |(d.stat & d.mask);
    end

    // State register; clock enable freezes everything
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            q      <= '0;
            q.ctrl <= unb_pkg::CTRL_RST; // RULE8
            q.acmp <= unb_pkg::ACMP_RST;
            q.stat <= unb_pkg::STAT_RST;
            q.mask <= unb_pkg::MASK_RST;
            q.txd  <= 1'b1; // Idle line is mark
        end
        else if (ce_i)
        begin
            q <= d;
        end
    end

    // Outputs straight from the state flops
    assign rd_data_o            = q.rdata;
    assign irq_o                = q.irq;
    assign rx_irq_req_o         = q.req;
    assign tx_busy_o            = q.busy;
    assign txd_o                = q.txd;
    assign line_driver_enable_o = q.de;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // Received character while ninth-bit mode is active
    sequence s_rx_mp;
        ce_i && rx_valid_i && q.ctrl[unb_pkg::CTRL_EN];
    endsequence

    // Last data bit leaves the shifter
    sequence s_last_data;
        ce_i && baud_tick_i && q.tx == unb_pkg::TX_DATA
        && q.cnt == unb_pkg::BIT_LAST;
    endsequence

    // Every byte asks for service in mode 00
    a_mode_all_req: assert property ( // RULE1
        s_rx_mp and mode_of(q.ctrl) == unb_pkg::MODE_ALL
        |=> rx_irq_req_o)
        else $error("mode 00 byte without request");

    // Only address bytes ask for service in mode 01
    a_mode_addr_only: assert property ( // RULE2
        s_rx_mp and mode_of(q.ctrl) == unb_pkg::MODE_ADDR
        |=> rx_irq_req_o == $past(rx_i.ninth))
        else $error("mode 01 request wrong");

    // Matching address and following data in mode 10
    a_mode_match_run: assert property ( // RULE3
        s_rx_mp and mode_of(q.ctrl) == unb_pkg::MODE_MATCH
        |=> rx_irq_req_o == ($past(rx_i.ninth)
            ? ($past(rx_i.data) == $past(q.acmp)) : $past(q.match)))
        else $error("mode 10 request wrong");

    // Mode 11 serves data only, after a matching address
    a_mode_data_only: assert property ( // RULE4
        s_rx_mp and mode_of(q.ctrl) == unb_pkg::MODE_DATA
        |=> rx_irq_req_o == (!$past(rx_i.ninth) && $past(q.match)))
        else $error("mode 11 request wrong");

    // Enable bit follows a control write in the right bank
    a_enable_write: assert property ( // RULE5
        ce_i && req_i.wr && req_i.addr == unb_pkg::CTRL_ADDR && bank_ok
        |=> q.ctrl[unb_pkg::CTRL_EN] == $past(req_i.wdata[6]))
        else $error("enable bit not written");

    // Ninth slot carries the latched ninth value
    a_ninth_value: assert property ( // RULE6
        q.tx == unb_pkg::TX_NINTH |-> txd_o == q.ninth_bit)
        else $error("ninth bit value wrong");

    // Driver enable level tracks busy and polarity
    a_de_polarity: assert property ( // RULE7
        line_driver_enable_o ==
        ((q.tx != unb_pkg::TX_IDLE) ^ q.ctrl[unb_pkg::CTRL_POL]))
        else $error("driver enable level wrong");

    // Other banks leave the control register untouched
    a_bank_gate: assert property ( // RULE8
        ce_i && req_i.wr && req_i.addr == unb_pkg::CTRL_ADDR && !bank_ok
        |=> $stable(q.ctrl))
        else $error("control written in wrong bank");

    // Readback of control in its bank
    a_ctrl_read: assert property ( // RULE8
        ce_i && req_i.rd && req_i.addr == unb_pkg::CTRL_ADDR && bank_ok
        |=> rd_data_o == $past(q.ctrl))
        else $error("control readback wrong");

    // Ninth slot sits between data bits and stop
    a_frame_order: assert property ( // RULE9
        s_last_data and q.ninth_en
        |=> q.tx == unb_pkg::TX_NINTH ##1 (q.tx == unb_pkg::TX_NINTH
            || q.tx == unb_pkg::TX_STOP))
        else $error("ninth slot out of place");

    // Address bytes flag the address event
    a_addr_class: assert property ( // RULE10
        s_rx_mp and rx_i.ninth |=> q.stat[unb_pkg::ST_ADDR])
        else $error("address byte not classed");

    // Match result held across data bytes
    a_match_hold: assert property ( // RULE11
        ce_i && rx_valid_i && !is_addr |=> $stable(q.match))
        else $error("match lost on data byte");

    // Framer takes a character only when idle
    sequence s_tx_take;
        ce_i && tx_start_i && q.tx == unb_pkg::TX_IDLE;
    endsequence

    // A fresh event is kept even if cleared in the same cycle
    a_stat_set_wins: assert property ( // RULE1
        ce_i && st_set[unb_pkg::ST_RXREQ] |=> q.stat[unb_pkg::ST_RXREQ])
        else $error("request event lost to clear");

    // Writing one clears a quiet request flag
    a_stat_w1c: assert property ( // RULE1
        ce_i && req_i.wr && req_i.addr == unb_pkg::STAT_ADDR
        && req_i.wdata[unb_pkg::ST_RXREQ] && !st_set[unb_pkg::ST_RXREQ]
        |=> !q.stat[unb_pkg::ST_RXREQ])
        else $error("request flag not cleared");

    // Level output follows unmasked sticky flags
    a_irq_level: assert property ( // RULE1
        irq_o == |(q.stat & q.mask))
        else $error("interrupt level wrong");

    // Read data stands one cycle, then returns to zero
    a_read_idle: assert property ( // RULE8
        ce_i && !req_i.rd |=> rd_data_o == 8'h00)
        else $error("read data not cleared");

    // With ninth-bit mode off every byte asks for service
    a_plain_all_req: assert property ( // RULE5
        ce_i && rx_valid_i && !q.ctrl[unb_pkg::CTRL_EN]
        |=> rx_irq_req_o)
        else $error("plain byte without request");

    // Each address byte renews the match result
    a_match_update: assert property ( // RULE11
        s_rx_mp and rx_i.ninth
        |=> q.match == ($past(rx_i.data) == $past(q.acmp)))
        else $error("match not renewed");

    // Accepted start drives the start bit and asserts the driver
    a_tx_take: assert property ( // RULE7
        s_tx_take |=> tx_busy_o && !txd_o
        && line_driver_enable_o != q.ctrl[unb_pkg::CTRL_POL])
        else $error("start bit or driver enable wrong");

    // Ninth value and enable are frozen for the whole character
    a_ninth_latch: assert property ( // RULE6
        s_tx_take |=> q.ninth_bit == $past(q.ctrl[unb_pkg::CTRL_TXB])
        && q.ninth_en == $past(q.ctrl[unb_pkg::CTRL_EN]))
        else $error("ninth value not latched");

    // A start while busy must not disturb the running character
    a_busy_ignore: assert property ( // RULE6
        ce_i && tx_start_i && q.tx != unb_pkg::TX_IDLE
        |=> $stable(q.ninth_bit) && $stable(q.ninth_en))
        else $error("start accepted while busy");

    // Without ninth-bit mode the stop bit follows the last data bit
    a_plain_frame: assert property ( // RULE5
        s_last_data and !q.ninth_en
        |=> q.tx == unb_pkg::TX_STOP && txd_o)
        else $error("plain frame carries a ninth slot");

    // Stop bit ends the character and records the event
    a_stop_done: assert property ( // RULE9
        ce_i && baud_tick_i && q.tx == unb_pkg::TX_STOP
        |=> !tx_busy_o && txd_o && q.stat[unb_pkg::ST_TXDONE])
        else $error("character did not end cleanly");

endmodule : unb_ninth_bit_ctrl

// [logic/unb_pkg.sv]
// Constants, carriers and state type of the ninth-bit serial control block
package unb_pkg;

    // Bus widths
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;

    // Register byte addresses
    localparam logic [11:0] CTRL_ADDR = 12'hf43;
    localparam logic [11:0] ACMP_ADDR = 12'hf60;
    localparam logic [11:0] STAT_ADDR = 12'hf61;
    localparam logic [11:0] MASK_ADDR = 12'hf62;

    // Bank that exposes the control register at the shared address
    localparam logic [2:0] BANK_MP = 3'h0;

    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] ACMP_RST = 8'h00;
    localparam logic [2:0] STAT_RST = 3'h0;
    localparam logic [2:0] MASK_RST = 3'h0;

    // Control field positions
    localparam int CTRL_MODE_HI = 7;
    localparam int CTRL_EN      = 6;
    localparam int CTRL_MODE_LO = 5;
    localparam int CTRL_TXB     = 4;
    localparam int CTRL_POL     = 3;

    // Status and mask bit positions
    localparam int ST_RXREQ  = 0;
    localparam int ST_ADDR   = 1;
    localparam int ST_TXDONE = 2;
    localparam int ST_W      = 3;

    // Receive interrupt filter modes
    localparam logic [1:0] MODE_ALL   = 2'h0;
    localparam logic [1:0] MODE_ADDR  = 2'h1;
    localparam logic [1:0] MODE_MATCH = 2'h2;
    localparam logic [1:0] MODE_DATA  = 2'h3;

    // Index of the last data bit of a character
    localparam logic [2:0] BIT_LAST = 3'h7;

    // Transmit sequencer states
    typedef enum logic [2:0] {
        TX_IDLE,
        TX_START,
        TX_DATA,
        TX_NINTH,
        TX_STOP
    } unb_tx_t;

    // Register port request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [7:0]  wdata;
    } unb_req_t;

    // Received character
    typedef struct packed {
        logic       ninth;
        logic [7:0] data;
    } unb_rx_t;

    // Complete state of the block
    typedef struct packed {
        logic [7:0]  ctrl;
        logic [7:0]  acmp;
        logic [2:0]  stat;
        logic [2:0]  mask;
        logic        match;
        logic [7:0]  rdata;
        logic        irq;
        logic        req;
        unb_tx_t     tx;
        logic [7:0]  shift;
        logic [2:0]  cnt;
        logic        ninth_bit;
        logic        ninth_en;
        logic        txd;
        logic        de;
        logic        busy;
    } unb_state_t;

endpackage : unb_pkg

// [tb/unb_peer.sv]
// Far-side serial node: bit clock, line sampler, character source
`timescale 1ns/1ns
module unb_peer (
    input  wire logic        clk_i,  // System clock
    input  wire logic        rst_i,  // Async reset
    input  wire logic        txd_i,  // Line from the block
    output logic             tick_o, // Bit-time pulse
    output logic [11:0]      line_o, // Last twelve line samples
    output logic             rxv_o,  // Character strobe
    output unb_pkg::unb_rx_t rx_o    // Character
);
    logic [1:0] div_q;

    // Bit clock every fourth cycle; line sampled on each tick at the end of the bit, just before the block moves on
    always_ff @(posedge clk_i or posedge rst_i)
        if (rst_i)
        begin
            div_q  <= 2'h0;
            line_o <= 12'hfff;
        end
        else
        begin
            div_q <= div_q + 2'h1;
            if (tick_o)
                line_o <= {txd_i, line_o[11:1]};
        end
    assign tick_o = (div_q == 2'h3);

    // One character; released bus shows inverse so stale data never matches
    task automatic send(input logic nb, input logic [7:0] d);
        rxv_o <= 1'b1;
        rx_o  <= {nb, d};
        @(posedge clk_i);
        rxv_o <= 1'b0;
        rx_o  <= ~{nb, d};
    endtask : send

    // Idle bus at time zero
    initial
    begin
        rxv_o = 1'b0;
        rx_o  = '0;
    end
endmodule : unb_peer

// [tb/tb_top.sv]
// Self-checking bench for the ninth-bit serial control block
`timescale 1ns/1ns
module tb_top;
    logic              clk_i;
    logic              rst_i;
    logic              ce;
    logic [2:0]        bank;
    unb_pkg::unb_req_t req;
    logic              rxv;
    unb_pkg::unb_rx_t  rx;
    logic              tick;
    logic              tx_start;
    logic [7:0]        tx_data;
    logic [7:0]        rd_data;
    logic              irq;
    logic              rx_req;
    logic              busy;
    logic              txd;
    logic              de;
    logic [11:0]       line;
    int                num_errors;
    int                tests_run;

    unb_ninth_bit_ctrl dut (
        .clk_i                (clk_i),
        .rst_i                (rst_i),
        .ce_i                 (ce),
        .bank_select_field_i  (bank),
        .req_i                (req),
        .rd_data_o            (rd_data),
        .irq_o                (irq),
        .rx_valid_i           (rxv),
        .rx_i                 (rx),
        .rx_irq_req_o         (rx_req),
        .baud_tick_i          (tick),
        .tx_start_i           (tx_start),
        .tx_data_i            (tx_data),
        .tx_busy_o            (busy),
        .txd_o                (txd),
        .line_driver_enable_o (de)
    );

    unb_peer peer (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .txd_i  (txd),
        .tick_o (tick),
        .line_o (line),
        .rxv_o  (rxv),
        .rx_o   (rx)
    );

    task automatic test_done();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : test_done

    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_i);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_i);
        req <= '0;
    endtask : wr

    // Read data only stands in the cycle after the strobe
    task automatic rdc(input logic [11:0] a, input logic [7:0] e);
        @(posedge clk_i);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk_i);
        req <= '0;
        #1 chk({4'h0, rd_data}, {4'h0, e});
    endtask : rdc

    task automatic t_regs();
        rdc(unb_pkg::CTRL_ADDR, 8'h00);
        rdc(12'hf44, 8'h00);
        chk(12'(de), 12'h000);
        @(posedge clk_i);
        bank <= 3'h1;
        wr(unb_pkg::CTRL_ADDR, 8'hff);
        rdc(unb_pkg::CTRL_ADDR, 8'h00);
        @(posedge clk_i);
        bank <= 3'h0;
        rdc(unb_pkg::CTRL_ADDR, 8'h00);
        wr(unb_pkg::CTRL_ADDR, 8'h5a);
        rdc(unb_pkg::CTRL_ADDR, 8'h5a);
        wr(unb_pkg::CTRL_ADDR, 8'ha5);
        rdc(unb_pkg::CTRL_ADDR, 8'ha5);
        // Frozen clock enable must drop the write
        @(posedge clk_i);
        ce <= 1'b0;
        wr(unb_pkg::CTRL_ADDR, 8'h3c);
        ce <= 1'b1;
        rdc(unb_pkg::CTRL_ADDR, 8'ha5);
        $display("regs done");
    endtask : t_regs

    // Address 42 matches, 13 does not; data bytes in between
    task automatic t_filter();
        logic [4:0] exp [4] = '{5'h1f, 5'h12, 5'h1c, 5'h0c};
        logic [8:0] sq [5] = '{9'h142, 9'h011, 9'h022, 9'h113, 9'h033};
        wr(unb_pkg::ACMP_ADDR, 8'h42);
        rdc(unb_pkg::ACMP_ADDR, 8'h42);
        for (int m = 0; m < 4; m++)
        begin
            wr(unb_pkg::CTRL_ADDR, {m[1], 1'b1, m[0], 5'h00});
            for (int i = 0; i < 5; i++)
            begin
                @(posedge clk_i);
                peer.send(sq[i][8], sq[i][7:0]);
                #1 chk(12'(rx_req), 12'(exp[m][4-i]));
            end
        end
        wr(unb_pkg::CTRL_ADDR, 8'h20);
        @(posedge clk_i);
        peer.send(1'b0, 8'h44);
        #1 chk(12'(rx_req), 12'h001);
        $display("filter done");
    endtask : t_filter

    // Sticky status, masked level output, write-one clear
    task automatic t_irq();
        rdc(unb_pkg::STAT_ADDR, 8'h03);
        chk(12'(irq), 12'h000);
        wr(unb_pkg::MASK_ADDR, 8'h01);
        repeat (2) @(posedge clk_i);
        #1 chk(12'(irq), 12'h001);
        rdc(unb_pkg::MASK_ADDR, 8'h01);
        wr(unb_pkg::STAT_ADDR, 8'h01);
        rdc(unb_pkg::STAT_ADDR, 8'h02);
        #1 chk(12'(irq), 12'h000);
        $display("irq done");
    endtask : t_irq

    // Start held high into busy: the second request must be ignored
    task automatic t_tx(input logic en, tb, pol, input logic [7:0] d);
        logic [11:0] e;
        int          n;
        wr(unb_pkg::CTRL_ADDR, {1'b0, en, 1'b0, tb, pol, 3'h0});
        wr(unb_pkg::STAT_ADDR, 8'h04);
        @(posedge clk_i);
        tx_start <= 1'b1;
        tx_data  <= d;
        @(posedge clk_i);
        tx_data <= ~d;
        #1 chk(12'(de), {11'h000, ~pol});
        @(posedge clk_i);
        tx_start <= 1'b0;
        for (n = 0; n < 200 && busy !== 1'b0; n++)
            @(posedge clk_i) #1;
        if (n == 200)
        begin
            num_errors++;
            test_done();
        end
        chk(12'(de), 12'(pol));
        e = en ? {2'b01, tb, d, 1'b0} : {3'b001, d, 1'b0};
        chk(en ? {1'b0, line[11:1]} : {2'b00, line[11:2]}, e);
        rdc(unb_pkg::STAT_ADDR, 8'h06);
        $display("tx done");
    endtask : t_tx

    // Free-running system clock
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // Main sequence
    initial
    begin
        num_errors = 0;
        tests_run  = 0;
        rst_i      = 1'b1;
        ce         = 1'b1;
        bank       = 3'h0;
        req        = '0;
        tx_start   = 1'b0;
        tx_data    = 8'h00;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_filter();
        t_irq();
        t_tx(1'b1, 1'b1, 1'b0, 8'h5a);
        t_tx(1'b1, 1'b0, 1'b1, 8'hc3);
        t_tx(1'b0, 1'b1, 1'b0, 8'h96);
        test_done();
    end
endmodule : tb_top
